// >>> rtl/rdsc_regs.vh
// register offsets, field layout and reset values of the downconverter
// stage control; included by rtl/rdsc_ctrl.v only.
`ifndef RDSC_REGS_VH
`define RDSC_REGS_VH

// register indices; the byte address is four times the index
`define RDSC_IDX_COARSE_EN   12'h0285
`define RDSC_IDX_FINE_EN     12'h0286
`define RDSC_IDX_BYPASS      12'h0287
`define RDSC_IDX_CHIP_RATIO  12'h0289
`define RDSC_IDX_OVL_BASE    12'h02C0
`define RDSC_IDX_STATUS      12'h02C8

// field layout
`define RDSC_COARSE_MSB      3
`define RDSC_FINE_MSB        7

// reset values
`define RDSC_RST_COARSE_EN   4'h0
`define RDSC_RST_FINE_EN     8'h00
`define RDSC_RST_BYPASS      8'h00
`define RDSC_RST_RATIO       8'h00

// bus answers
`define RDSC_RESP_OKAY       2'b00
`define RDSC_RESP_SLVERR     2'b10

`endif

// >>> rtl/rdsc_ctrl.v
// receive downconverter stage control: enables, fine bypass, rate match
// assumes one clock, samples and ADC_TICK synchronous to CLK, and that
// the fine filters themselves sit outside and are fed by coarse n/2.
// every register is 8 bits wide and travels in the low byte lane
// Functional notes
// - coarse enable bits [3:0], one per channel
// - fine enable bits [7:0], one per channel
// - bypass bit set: output feeding coarse samples
// - bypass clear: fine path only when enabled
// - hold-upsample channels to smallest link decimation
//
// Added by the designer: the AXI4-Lite slave port.
`include "rdsc_regs.vh"
`default_nettype none

module rdsc_ctrl #(
	parameter W = 16                      // sample width
) (
	// clock and reset
	input  wire           CLK,           // 20 MHz datapath clock
	input  wire           RST_B,         // async reset, active low

	// converter side: tick and filter samples
	input  wire           ADC_TICK,      // one pulse per converter sample
	input  wire [4*W-1:0] COARSE_DATA,   // coarse channel samples
	input  wire [3:0]     COARSE_VALID,  // coarse sample strobes
	input  wire [8*W-1:0] FINE_DATA,     // fine channel samples
	input  wire [7:0]     FINE_VALID,    // fine sample strobes

	// filter enables and samples toward the link
	output reg  [3:0]     COARSE_ENABLE, // enables to coarse filters
	output reg  [7:0]     FINE_ENABLE,   // enables to fine filters
	output reg  [8*W-1:0] OUT_DATA,      // samples to link transmitter
	output reg  [7:0]     OUT_VALID,     // output sample strobes

	// AXI4-Lite write channels
	input  wire [13:0]    S_AXI_AWADDR,  // write address
	input  wire           S_AXI_AWVALID, // write address valid
	output reg            S_AXI_AWREADY, // write address ready
	input  wire [31:0]    S_AXI_WDATA,   // write data
	input  wire [3:0]     S_AXI_WSTRB,   // write byte lanes
	input  wire           S_AXI_WVALID,  // write data valid
	output reg            S_AXI_WREADY,  // write data ready
	output reg  [1:0]     S_AXI_BRESP,   // write response
	output reg            S_AXI_BVALID,  // write response valid
	input  wire           S_AXI_BREADY,  // write response ready

	// AXI4-Lite read channels
	input  wire [13:0]    S_AXI_ARADDR,  // read address
	input  wire           S_AXI_ARVALID, // read address valid
	output reg            S_AXI_ARREADY, // read address ready
	output reg  [31:0]    S_AXI_RDATA,   // read data
	output reg  [1:0]     S_AXI_RRESP,   // read response
	output reg            S_AXI_RVALID,  // read data valid
	input  wire           S_AXI_RREADY   // read data ready
);

	// software state
	reg [7:0]  bypass;          // fine stage bypass per channel
	reg [7:0]  chip_ratio;      // smallest overall decimation of link
	reg [7:0]  ovl [0:7];       // overall decimation per fine channel
	reg [7:0]  active;          // channel currently producing output
	reg [7:0]  link_cnt;        // converter samples since last tick
	reg        link_tick;       // one pulse per output sample slot

	// write channel capture
	reg [11:0] aw_idx;
	reg        aw_held;
	reg [7:0]  w_byte;
	reg        w_lane;
	reg        w_held;
	// a store needs both halves and no answer still waiting
	wire       do_write = aw_held & w_held & ~S_AXI_BVALID;
	// overall decimation block: eight words from its base index up
	localparam [11:0] OVL_BASE = `RDSC_IDX_OVL_BASE;
	wire       wr_ovl   = (aw_idx[11:3] == OVL_BASE[11:3]);
	wire [2:0] wr_ch    = aw_idx[2:0];
	wire [7:0] ovl_hit  = 8'h01 << wr_ch; // one-hot lane of that word

	// write address is held until the data also arrives, either order;
	// ready stays low meanwhile so a second address cannot slip in
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			aw_held       <= 1'b0;
			aw_idx        <= 12'h0000;
			S_AXI_AWREADY <= 1'b1;
		end else if (S_AXI_AWVALID & S_AXI_AWREADY) begin
			// address taken: park it for the data half
			aw_held       <= 1'b1;
			aw_idx        <= S_AXI_AWADDR[13:2];
			S_AXI_AWREADY <= 1'b0;
		end else if (do_write) begin
			aw_held       <= 1'b0;
			S_AXI_AWREADY <= 1'b1;
		end
	end

	// write data capture; only the low byte lane carries register bits
	// the upper lanes are taken but dropped: every register is 8 bits
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			w_held       <= 1'b0;
			w_byte       <= 8'h00;
			w_lane       <= 1'b0;
			S_AXI_WREADY <= 1'b1;
		end else if (S_AXI_WVALID & S_AXI_WREADY) begin
			// data taken: park low byte and lane strobe
			w_held       <= 1'b1;
			w_byte       <= S_AXI_WDATA[7:0];
			w_lane       <= S_AXI_WSTRB[0];
			S_AXI_WREADY <= 1'b0;
		end else if (do_write) begin
			w_held       <= 1'b0;
			S_AXI_WREADY <= 1'b1;
		end
	end

	// decode of the held write address
	// status is known, so a write there answers OKAY and stores nothing
	reg wr_known;
	always @* begin
		wr_known = wr_ovl;
		case (aw_idx)
			`RDSC_IDX_COARSE_EN:  wr_known = 1'b1;
			`RDSC_IDX_FINE_EN:    wr_known = 1'b1;
			`RDSC_IDX_BYPASS:     wr_known = 1'b1;
			`RDSC_IDX_CHIP_RATIO: wr_known = 1'b1;
			`RDSC_IDX_STATUS:     wr_known = 1'b1;
			default:              wr_known = wr_ovl;
		endcase
	end

	// control registers; all reset to zero so every channel starts off
	// a write with the lane 0 strobe off answers OKAY, changes nothing
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			// every lane dark and unbypassed
			COARSE_ENABLE <= `RDSC_RST_COARSE_EN;
			FINE_ENABLE   <= `RDSC_RST_FINE_EN;
			bypass        <= `RDSC_RST_BYPASS;
			chip_ratio    <= `RDSC_RST_RATIO;
		end else if (do_write & w_lane) begin
			case (aw_idx)
				`RDSC_IDX_COARSE_EN:
					COARSE_ENABLE <= w_byte[`RDSC_COARSE_MSB:0];
				`RDSC_IDX_FINE_EN:
					FINE_ENABLE <= w_byte;
				`RDSC_IDX_BYPASS:
					bypass <= w_byte;
				`RDSC_IDX_CHIP_RATIO:
					chip_ratio <= w_byte;
				default: ;
			endcase
		end
	end

	// per channel overall decimation; kept as flip-flops by index
	// eight words fill the block, so no index inside it is unmapped
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_ovl
			always @(posedge CLK or negedge RST_B) begin
				if (!RST_B)
					ovl[g] <= `RDSC_RST_RATIO;
				else if (do_write & w_lane & wr_ovl & ovl_hit[g])
					ovl[g] <= w_byte;
			end
		end
	endgenerate

	// write response once both halves have been taken
	// a waiting answer blocks the next store so no response is lost;
	// set and clear never meet because a store needs the answer gone
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `RDSC_RESP_OKAY;
		end else if (do_write) begin
			// unknown index: error answer, nothing stored
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= wr_known ? `RDSC_RESP_OKAY : `RDSC_RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// read mux; reserved coarse bits [7:4] read as zero
	// decoded straight off the bus; only used on the edge that takes
	// the address, so it needs no holding register
	wire [11:0] rd_idx = S_AXI_ARADDR[13:2];
	reg  [7:0]  rd_val;
	reg         rd_ok;
	always @* begin
		rd_val = 8'h00;
		rd_ok  = 1'b1;
		case (rd_idx)
			`RDSC_IDX_COARSE_EN:  rd_val = {4'h0, COARSE_ENABLE};
			`RDSC_IDX_FINE_EN:    rd_val = FINE_ENABLE;
			`RDSC_IDX_BYPASS:     rd_val = bypass;
			`RDSC_IDX_CHIP_RATIO: rd_val = chip_ratio;
			`RDSC_IDX_STATUS:     rd_val = active;
			default: begin
				if (rd_idx[11:3] == OVL_BASE[11:3])
					rd_val = ovl[rd_idx[2:0]];
				else
					rd_ok = 1'b0;
			end
		endcase
	end

	// read answer one cycle after the address is taken
	// one read at a time: the address port closes until data is taken
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= `RDSC_RESP_OKAY;
		end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b1;
			S_AXI_RDATA   <= {24'h00_0000, rd_val};
			S_AXI_RRESP   <= rd_ok ? `RDSC_RESP_OKAY : `RDSC_RESP_SLVERR;
		end else if (S_AXI_RVALID & S_AXI_RREADY) begin
			// answer taken: reopen the address port
			S_AXI_RVALID  <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	// link slot divider: one tick every chip_ratio converter samples;
	// a ratio of 0 or 1 ticks on every converter sample
	// limitation: the slot phase runs free of any frame marker,
	// and a new ratio takes hold at the next converter sample, even mid-slot
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			link_cnt  <= 8'h00;
			link_tick <= 1'b0;
		end else if (ADC_TICK) begin
			// count samples; wrap and tick at the ratio
			if (link_cnt + 8'h01 >= chip_ratio) begin
				link_cnt  <= 8'h00;
				link_tick <= 1'b1;
			end else begin
				link_cnt  <= link_cnt + 8'h01;
				link_tick <= 1'b0;
			end
		end else begin
			link_tick <= 1'b0;
		end
	end

	// per fine channel output selection and rate matching
	// trade-off: a zero-order hold is cheap but repeats samples
	// instead of interpolating; the link only needs the rates to match
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_ch
			localparam C = g / 2;     // coarse stage that feeds this one
			reg  [W-1:0] held;        // last sample, repeated on ticks
			// fine lane g hangs off coarse lane g/2
			wire         c_on = COARSE_ENABLE[C];
			wire         f_on = FINE_ENABLE[g] & c_on;
			wire         sel  = bypass[g];
			// bypass takes the coarse samples and ignores fine enable
			wire         on   = sel ? c_on : f_on;
			wire [W-1:0] s_d  = sel ? COARSE_DATA[C*W +: W]
			                        : FINE_DATA[g*W +: W];
			wire         s_v  = on & (sel ? COARSE_VALID[C]
			                              : FINE_VALID[g]);
			// already at the link ratio: pass, do not upsample
			wire         same = (ovl[g] == chip_ratio) |
			                    (chip_ratio == 8'h00);

			always @(posedge CLK or negedge RST_B) begin
				if (!RST_B) begin
					held                <= {W{1'b0}};
					active[g]           <= 1'b0;
					OUT_VALID[g]        <= 1'b0;
					OUT_DATA[g*W +: W]  <= {W{1'b0}};
				end else if (!on) begin
					// a disabled channel emits nothing at all
					held                <= {W{1'b0}};
					active[g]           <= 1'b0;
					OUT_VALID[g]        <= 1'b0;
				end else if (same) begin
					// pass mode: one cycle behind the source
					active[g]           <= 1'b1;
					OUT_VALID[g]        <= s_v;
					if (s_v)
						OUT_DATA[g*W +: W] <= s_d;
				end else begin
					// zero-order hold: the newest sample fills each slot
					active[g]           <= 1'b1;
					if (s_v)
						held <= s_d;
					OUT_VALID[g]        <= link_tick;
					if (link_tick)
						OUT_DATA[g*W +: W] <= s_v ? s_d : held;
				end
			end
		end
	endgenerate

endmodule // rdsc_ctrl

`default_nettype wire

// >>> tb/rdsc_chk_assertions.sv
// checker: bus timing and channel gating of rdsc_ctrl
// assumes only the top module's ports, bound at the foot
`default_nettype none
module rdsc_chk (
	input wire logic	CLK,	// clock
	input wire logic	RST_B,	// reset, active low
	input wire logic [3:0]	COARSE_ENABLE,	// coarse enables
	input wire logic [7:0]	FINE_ENABLE,	// fine enables
	input wire logic [7:0]	OUT_VALID,	// output strobes
	input wire logic	S_AXI_AWVALID,	// aw valid
	input wire logic	S_AXI_AWREADY,	// aw ready
	input wire logic	S_AXI_WVALID,	// w valid
	input wire logic	S_AXI_WREADY,	// w ready
	input wire logic	S_AXI_BVALID,	// b valid
	input wire logic	S_AXI_BREADY,	// b ready
	input wire logic	S_AXI_ARVALID,	// ar valid
	input wire logic	S_AXI_ARREADY,	// ar ready
	input wire logic	S_AXI_RVALID,	// r valid
	input wire logic	S_AXI_RREADY,	// r ready
	input wire logic [31:0]	S_AXI_RDATA	// read data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cx;
	// coarse enable seen by each fine lane; fine n hangs off coarse n/2
	assign cx = {{2{COARSE_ENABLE[3]}}, {2{COARSE_ENABLE[2]}},
		{2{COARSE_ENABLE[1]}}, {2{COARSE_ENABLE[0]}}};
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	AST_WR_ANSWER: assert property (S_AXI_AWVALID && S_AXI_AWREADY &&
		S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
		else $error("write answer late");
	AST_WR_BUSY: assert property (S_AXI_AWVALID && S_AXI_AWREADY
		|=> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write not busy");
	AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY
		|=> S_AXI_BVALID) else $error("write answer dropped");
	AST_RD_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY
		|=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("read answer late");
	AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY
		|=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read moved");
	AST_R_UPPER: assert property (S_AXI_RVALID |->
		S_AXI_RDATA[31:8] == 24'h00_0000) else $error("upper bits set");
	AST_OFF_SILENT: assert property (
		(OUT_VALID & ~cx & ~$past(cx)) == 8'h00) else $error("lane off");
	AST_RST_OFF: assert property ($rose(RST_B) |->
		COARSE_ENABLE == 4'h0 && FINE_ENABLE == 8'h00)
		else $error("enabled at reset");
endmodule // rdsc_chk
bind rdsc_ctrl rdsc_chk rdsc_chk_inst (.*);
`default_nettype wire

// >>> tb/rdsc_src.sv
// sample source: converter ticks and coarse and fine filter lanes
// assumes the clock of rdsc_ctrl; FIRE comes from the bench
`default_nettype none
module rdsc_src (
	input wire logic	CLK,	// clock
	input wire logic	RST_B,	// reset, active low
	input wire logic	FIRE,	// one sample on every lane
	output var logic	ADC_TICK,	// one pulse per 4 clocks
	output var logic [63:0]	COARSE_DATA,	// coarse lanes
	output var logic [3:0]	COARSE_VALID,	// coarse strobes
	output var logic [127:0]	FINE_DATA,	// fine lanes
	output var logic [7:0]	FINE_VALID	// fine strobes
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div;
	// idle lanes toggle so a stale sample never passes for a new one
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			div <= 2'h0;
			ADC_TICK <= 1'b0;
			COARSE_VALID <= 4'h0;
			FINE_VALID <= 8'h00;
			COARSE_DATA <= 64'h0;
			FINE_DATA <= 128'h0;
		end else begin
			div <= div + 2'h1;
			ADC_TICK <= (div == 2'h3);
			COARSE_VALID <= {4{FIRE}};
			FINE_VALID <= {8{FIRE}};
			for (int i = 0; i < 8; i++) begin
				FINE_DATA[i*16+:16] <= FIRE ? 16'hF000 + 16'(i)
					: ~FINE_DATA[i*16+:16];
				if (i < 4) COARSE_DATA[i*16+:16] <= FIRE
					? 16'hC000 + 16'(i) : ~COARSE_DATA[i*16+:16];
			end
		end
	end
endmodule // rdsc_src
`default_nettype wire

// >>> tb/tb_rdsc_ctrl.sv
// bench for rdsc_ctrl: AXI4-Lite registers, lane gating, rate match
// assumes rdsc_src as sample source and the bound checker
`default_nettype none
module tb_rdsc_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [1:0] OK = 2'b00, ER = 2'b10;
	// byte address is four times the register index
	localparam logic [13:0] A_CE = 14'h0A14, A_FE = 14'h0A18;
	localparam logic [13:0] A_BP = 14'h0A1C, A_RT = 14'h0A24;
	localparam logic [13:0] A_OV = 14'h0B00, A_UN = 14'h0A20;
	localparam logic [13:0] A_ST = 14'h0B20;
	// rows: coarse en, fine en, bypass, expected strobes
	logic [27:0] tv [7] = '{28'h101_0001, 28'h100_0101, 28'hFFF_F0FF,
		28'h5FF_0033, 28'hF00_0000, 28'h0FF_FF00, 28'hA0F_C0CC};
	logic CLK = 0, RST_B = 0, FIRE = 0, ADC_TICK;
	logic [63:0] COARSE_DATA;
	logic [127:0] FINE_DATA, OUT_DATA;
	logic [3:0] COARSE_VALID, COARSE_ENABLE, S_AXI_WSTRB = 4'hF;
	logic [7:0] FINE_VALID, FINE_ENABLE, OUT_VALID;
	logic [13:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
	logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
	logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, S_AXI_AWREADY;
	logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	int n_errors = 0, samples_checked = 0, k, n, cnt;
	rdsc_ctrl rdsc_ctrl_inst (.*);
	rdsc_src rdsc_src_inst (.*);
	initial forever #25 CLK = ~CLK;
	task automatic wrap_up;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	// ready is raised late on purpose so the hold checks get exercised
	task automatic axw(input logic [13:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int i;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1;
		S_AXI_WVALID <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge CLK);
			if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 0;
			if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 0;
			if (S_AXI_BVALID && S_AXI_BREADY) break;
			if (S_AXI_BVALID) S_AXI_BREADY <= 1;
		end
		S_AXI_BREADY <= 0;
		chk(i < 20 ? S_AXI_BRESP : 2'bxx, r);
		if (i == 20) wrap_up();
		@(posedge CLK);
	endtask
	task automatic axr(input logic [13:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int i;
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge CLK);
			if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 0;
			if (S_AXI_RVALID && S_AXI_RREADY) break;
			if (S_AXI_RVALID) S_AXI_RREADY <= 1;
		end
		S_AXI_RREADY <= 0;
		chk({S_AXI_RRESP, S_AXI_RDATA[29:0]}, {r, d[29:0]});
		if (i == 20) wrap_up();
		@(posedge CLK);
	endtask
	// source strobes land one edge after FIRE, outputs one edge later
	task automatic fire;
		FIRE <= 1;
		@(posedge CLK);
		FIRE <= 0;
		repeat (2) @(posedge CLK);
	endtask
	initial begin
		repeat (16) @(posedge CLK);
		RST_B <= 1;
		@(posedge CLK);
		chk({COARSE_ENABLE, FINE_ENABLE}, 0);
		for (k = 0; k < 3; k++) axr(A_CE + 4 * k, 0, OK);
		axw(A_CE, 32'hFF, OK);
		axr(A_CE, 32'h0F, OK);
		axw(A_UN, 32'h1, ER);
		axr(A_UN, 0, ER);
		foreach (tv[j]) begin
			axw(A_CE, tv[j][27:24], OK);
			axw(A_FE, tv[j][23:16], OK);
			axw(A_BP, tv[j][15:8], OK);
			fire();
			chk(OUT_VALID, tv[j][7:0]);
			chk({COARSE_ENABLE, FINE_ENABLE}, tv[j][27:16]);
			axr(A_ST, tv[j][7:0], OK);
			for (n = 0; n < 8; n++) if (tv[j][n]) chk(OUT_DATA[n*16+:16],
				tv[j][8+n] ? 16'hC000 + n / 2 : 16'hF000 + n);
		end
		axw(A_RT, 2, OK);
		axw(A_OV, 4, OK);
		axw(A_CE, 1, OK);
		axw(A_FE, 1, OK);
		axw(A_BP, 0, OK);
		fire();
		cnt = 0;
		repeat (32) @(posedge CLK) cnt += OUT_VALID[0];
		chk(cnt, 4);
		chk(OUT_DATA[15:0], 16'hF000);
		axw(A_OV, 2, OK);
		fire();
		chk(OUT_VALID, 8'h01);
		axr(A_OV, 2, OK);
		// a write with lane 0 off must leave the register alone
		S_AXI_WSTRB <= 4'h0;
		axw(A_CE, 32'h0F, OK);
		S_AXI_WSTRB <= 4'hF;
		axr(A_CE, 1, OK);
		axw(A_ST, 32'hFF, OK);
		axr(A_ST, 1, OK);
		// a second reset mid-run must clear every register again
		RST_B <= 0;
		repeat (2) @(posedge CLK);
		RST_B <= 1;
		@(posedge CLK);
		chk({COARSE_ENABLE, FINE_ENABLE, OUT_VALID}, 0);
		for (k = 0; k < 3; k++) axr(A_CE + 4 * k, 0, OK);
		axr(A_RT, 0, OK);
		axr(A_OV, 0, OK);
		axr(A_ST, 0, OK);
		wrap_up();
	end
endmodule // tb_rdsc_ctrl
`default_nettype wire
